// ===== src/spi_flag_pkg.sv
package spi_flag_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFF_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFF_CONTROL_TWO = 8'h04;
    localparam logic [7:0] OFF_BAUD_DIVIDER = 8'h08;
    localparam logic [7:0] OFF_FLAG_STATUS = 8'h0c;
    localparam logic [7:0] OFF_MATCH_VALUE = 8'h10;
    localparam logic [7:0] OFF_TX_RX_DATA = 8'h14;
    // control_one fields
    localparam int C1_RX_IRQ = 7;
    localparam int C1_ENABLE = 6;
    localparam int C1_TX_IRQ = 5;
    localparam int C1_MASTER = 4;
    localparam int C1_POLARITY = 3;
    localparam int C1_PHASE = 2;
    localparam int C1_SS_OUT = 1;
    localparam int C1_LOW_FIRST = 0;
    // control_two fields
    localparam int C2_MATCH_IRQ = 7;
    localparam int C2_FAULT_EN = 4;
    localparam int C2_SHARED_OE = 3;
    localparam int C2_STOP_WAIT = 1;
    localparam int C2_SINGLE_PIN = 0;
    localparam logic [7:0] C2_WRITE_MASK = 8'h9b;
    // baud_divider fields
    localparam int BR_PRE_HI = 6;
    localparam int BR_PRE_LO = 4;
    localparam int BR_RATE_HI = 3;
    localparam logic [7:0] BR_WRITE_MASK = 8'h7f;
    // reset values, bits per byte and divider width
    localparam logic [7:0] C1_RESET = 8'h04;
    localparam logic [7:0] C2_RESET = 8'h00;
    localparam logic [7:0] BR_RESET = 8'h00;
    localparam logic [7:0] MATCH_RESET = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int DIV_W = 20;

    typedef enum logic [1:0] {
        ENG_IDLE,
        ENG_MASTER,
        ENG_SLAVE
    } engine_e;
endpackage

// ===== src/spi_flag_core.sv
// Function
// - no interrupt request at all while system_enable is clear
// - rx_fault_irq_enable gates rx_full_flag and fault_flag onto the request
// - tx_irq_enable gates tx_empty_flag onto the request
// - match_irq_enable gates match_flag onto the request
// - one request line: any flag with its mask; flags stay pollable
// - fault_flag set aborts the transfer and clears master_select
// - fault request holds while fault_flag is set, drops when cleared
// - rx_full_flag sets when a received byte lands in the data buffer
// - a byte finishing while rx_full_flag is still set is discarded
// - tx_empty_flag sets when the transmit buffer can take a byte
// - match_flag sets when received data equals match_value
// - wake pulse: rx irq enabled, slave, low power, transfer ends
// - after low power ends, move held byte to data, then set flags
// - another byte ending during low power overwrites the held one
// - control_one bits 7..0: rx irq, enable, tx irq, master, pol, phase...
// - polarity 0 idle low; phase 1 edge at bit start; lsb 0 sends msb
// - control_two: 7 match irq, 4 fault en, 3 shared oe, 1 wait, 0 single
// - single pin 0 two data pins; shared oe 0 input; wait 0 keeps running
// - baud: prescale 6:4 (000 = /1), rate 3:0 (0000 = /2), bit 7 reserved
// - status: 7 rx full, 6 match, 5 tx empty, 4 fault, 3:0 zero
// - match_value and tx_rx_data are eight bits wide
// - fault_flag clears by status read seeing it, then control_one write
// - low select in master sets fault only if fault enable; never in slave
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
module spi_flag_core
    import spi_flag_pkg::*;
(
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic wait_mode, // cpu in wait mode
    input wire logic stop_mode, // cpu in state-keeping stop
    output logic irq, // interrupt request
    output logic wake_irq, // low power wake pulse
    input wire logic sck_in, // serial clock pin in
    output logic sck_out, // serial clock pin out
    output logic sck_oe_n, // serial clock drive, low drives
    input wire logic mosi_in, // master-out data pin in
    output logic mosi_out, // master-out data pin out
    output logic mosi_oe_n, // master-out drive, low drives
    input wire logic miso_in, // master-in data pin in
    output logic miso_out, // master-in data pin out
    output logic miso_oe_n, // master-in drive, low drives
    input wire logic ss_in_n, // slave select pin in
    output logic ss_out, // slave select pin out
    output logic ss_oe_n // slave select drive, low drives
);

    typedef struct packed {
        logic [1:0] sck_s, mosi_s, miso_s, ss_n_s;
        logic sck_q;
        logic [7:0] control_one, control_two, baud_divider, match_value;
        logic [7:0] rx_data, tx_buf;
        logic rx_full_flag, match_flag, tx_empty_flag, fault_flag;
        logic rx_armed, match_armed, tx_armed, fault_armed;
        engine_e eng;
        logic [7:0] tx_sh, rx_sh;
        logic [3:0] edges;
        logic [DIV_W-1:0] div_cnt;
        logic sck_gen, pend_valid;
        logic [7:0] pend_data;
        logic [31:0] prdata;
        logic pready, pslverr, irq, wake_irq;
        logic sck_out, sck_oe_n, mosi_out, mosi_oe_n;
        logic miso_out, miso_oe_n, ss_out, ss_oe_n;
    } state_s;

    localparam state_s RESET_STATE = '{
        ss_n_s: 2'h3,
        control_one: C1_RESET,
        control_two: C2_RESET,
        baud_divider: BR_RESET,
        match_value: MATCH_RESET,
        tx_empty_flag: 1'b1,
        eng: ENG_IDLE,
        sck_oe_n: 1'b1,
        mosi_oe_n: 1'b1,
        miso_oe_n: 1'b1,
        ss_out: 1'b1,
        ss_oe_n: 1'b1,
        default: '0
    };

    state_s s;
    state_s next_s;

    logic system_enable, master_select, clock_polarity, clock_phase;
    logic select_output_enable, low_bit_first, fault_detect_enable;
    logic shared_pin_output_enable, stop_in_wait, single_pin_select;
    logic low_power, data_in, access_done, bus_write, bus_read, mapped;
    logic [7:0] rd_val, status_val, rx_shifted, tx_shifted, done_byte;
    logic [DIV_W-1:0] half_m1;
    logic tick, fault_hit, sck_edge, sck_lead, sample_now, shift_now;
    logic mlead, done, drive_master, drive_slave;

    assign system_enable = s.control_one[C1_ENABLE];
    assign master_select = s.control_one[C1_MASTER];
    assign clock_polarity = s.control_one[C1_POLARITY];
    assign clock_phase = s.control_one[C1_PHASE];
    assign select_output_enable = s.control_one[C1_SS_OUT];
    assign low_bit_first = s.control_one[C1_LOW_FIRST];
    assign fault_detect_enable = s.control_two[C2_FAULT_EN];
    assign shared_pin_output_enable = s.control_two[C2_SHARED_OE];
    assign stop_in_wait = s.control_two[C2_STOP_WAIT];
    assign single_pin_select = s.control_two[C2_SINGLE_PIN];

    // wait mode halts the module only with stop_in_wait set
    assign low_power = (wait_mode & stop_in_wait) | stop_mode;

    // data input pin follows mode and single-pin selection
    assign data_in = master_select
        ? (single_pin_select ? s.mosi_s[1] : s.miso_s[1])
        : (single_pin_select ? s.miso_s[1] : s.mosi_s[1]);

    assign access_done = psel & penable & s.pready & ~s.pslverr;
    assign bus_write = access_done & pwrite;
    assign bus_read = access_done & ~pwrite;

    assign status_val = {s.rx_full_flag, s.match_flag, s.tx_empty_flag,
        s.fault_flag, 4'h0};

    assign mapped = (paddr == OFF_CONTROL_ONE)
        | (paddr == OFF_CONTROL_TWO) | (paddr == OFF_BAUD_DIVIDER)
        | (paddr == OFF_FLAG_STATUS) | (paddr == OFF_MATCH_VALUE)
        | (paddr == OFF_TX_RX_DATA);

    assign rd_val = (paddr == OFF_CONTROL_ONE) ? s.control_one
        : (paddr == OFF_CONTROL_TWO) ? s.control_two
        : (paddr == OFF_BAUD_DIVIDER) ? s.baud_divider
        : (paddr == OFF_FLAG_STATUS) ? status_val
        : (paddr == OFF_MATCH_VALUE) ? s.match_value
        : (paddr == OFF_TX_RX_DATA) ? s.rx_data
        : 8'h00;

    // half bit time is (prescale + 1) << rate bus cycles
    assign half_m1 = DIV_W'(({17'h0,
        s.baud_divider[BR_PRE_HI:BR_PRE_LO]} + 20'h1)
        << s.baud_divider[BR_RATE_HI:0]) - 20'h1;
    assign tick = s.div_cnt >= half_m1;

    assign rx_shifted = low_bit_first ? {data_in, s.rx_sh[7:1]}
        : {s.rx_sh[6:0], data_in};
    assign tx_shifted = low_bit_first ? {1'b0, s.tx_sh[7:1]}
        : {s.tx_sh[6:0], 1'b0};

    // select low while master, detection armed, select not driven
    assign fault_hit = system_enable & master_select & fault_detect_enable
        & ~select_output_enable & ~s.ss_n_s[1];

    assign sck_edge = s.sck_s[1] ^ s.sck_q;
    assign sck_lead = sck_edge & (s.sck_s[1] != clock_polarity);

    always_comb begin
        next_s = s;
        done = 1'b0;
        done_byte = s.rx_sh;
        sample_now = 1'b0;
        shift_now = 1'b0;
        mlead = 1'b0;
        drive_master = 1'b0;
        drive_slave = 1'b0;

        next_s.sck_s = {s.sck_s[0], sck_in};
        next_s.mosi_s = {s.mosi_s[0], mosi_in};
        next_s.miso_s = {s.miso_s[0], miso_in};
        next_s.ss_n_s = {s.ss_n_s[0], ss_in_n};
        next_s.sck_q = s.sck_s[1];
        next_s.wake_irq = 1'b0;

        // one wait state, read data captured with pready
        next_s.pready = psel & penable & ~s.pready;
        next_s.pslverr = 1'b0;
        next_s.prdata = '0;
        if (next_s.pready) begin
            next_s.pslverr = ~mapped;
            next_s.prdata = {24'h0, rd_val};
        end

        // status read arms the clearing sequences
        if (bus_read && paddr == OFF_FLAG_STATUS) begin
            next_s.rx_armed = s.rx_full_flag;
            next_s.match_armed = s.match_flag;
            next_s.tx_armed = s.tx_empty_flag;
            next_s.fault_armed = s.fault_flag;
        end
        if (bus_read && paddr == OFF_TX_RX_DATA) begin
            if (s.rx_armed) begin
                next_s.rx_full_flag = 1'b0;
                next_s.rx_armed = 1'b0;
            end
            if (s.match_armed) begin
                next_s.match_flag = 1'b0;
                next_s.match_armed = 1'b0;
            end
        end
        if (bus_write) begin
            unique case (paddr)
                OFF_CONTROL_ONE: begin
                    next_s.control_one = pwdata[7:0];
                    if (s.fault_armed) begin
                        next_s.fault_flag = 1'b0;
                        next_s.fault_armed = 1'b0;
                    end
                end
                OFF_CONTROL_TWO:
                    next_s.control_two = pwdata[7:0] & C2_WRITE_MASK;
                OFF_BAUD_DIVIDER:
                    next_s.baud_divider = pwdata[7:0] & BR_WRITE_MASK;
                OFF_MATCH_VALUE:
                    next_s.match_value = pwdata[7:0];
                OFF_TX_RX_DATA: begin
                    // only a write after the status read is taken
                    if (s.tx_armed) begin
                        next_s.tx_buf = pwdata[7:0];
                        next_s.tx_empty_flag = 1'b0;
                        next_s.tx_armed = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // serial engine
        if (!system_enable) begin
            next_s.eng = ENG_IDLE;
            next_s.edges = '0;
            next_s.sck_gen = clock_polarity;
        end else if (master_select) begin
            unique case (s.eng)
                ENG_IDLE: begin
                    next_s.sck_gen = clock_polarity;
                    if (!s.tx_empty_flag && !low_power) begin
                        next_s.tx_sh = s.tx_buf;
                        next_s.tx_empty_flag = 1'b1;
                        next_s.edges = '0;
                        next_s.div_cnt = '0;
                        next_s.eng = ENG_MASTER;
                    end
                end
                ENG_MASTER: begin
                    // master shifting freezes in low power
                    if (!low_power && tick) begin
                        next_s.div_cnt = '0;
                        next_s.sck_gen = ~s.sck_gen;
                        mlead = s.sck_gen == clock_polarity;
                        sample_now = mlead ^ clock_phase;
                        shift_now = ~sample_now && s.edges != '0
                            && s.edges != BITS_PER_BYTE;
                        if (sample_now) begin
                            next_s.rx_sh = rx_shifted;
                            next_s.edges = s.edges + 4'h1;
                        end
                        if (shift_now) begin
                            next_s.tx_sh = tx_shifted;
                        end
                        if (!mlead && next_s.edges == BITS_PER_BYTE) begin
                            done = 1'b1;
                            done_byte = next_s.rx_sh;
                            next_s.edges = '0;
                            next_s.eng = ENG_IDLE;
                        end
                    end else if (!low_power) begin
                        next_s.div_cnt = s.div_cnt + 20'h1;
                    end
                end
                ENG_SLAVE: begin
                    next_s.eng = ENG_IDLE;
                    next_s.edges = '0;
                end
            endcase
        end else if (s.ss_n_s[1]) begin
            next_s.eng = ENG_IDLE;
            next_s.edges = '0;
        end else if (s.eng != ENG_SLAVE) begin
            next_s.eng = ENG_SLAVE;
            next_s.edges = '0;
            if (!s.tx_empty_flag) begin
                next_s.tx_sh = s.tx_buf;
                next_s.tx_empty_flag = 1'b1;
            end else begin
                next_s.tx_sh = s.rx_sh;
            end
        end else if (sck_edge) begin
            // slave keeps shifting in low power, clocked by the master
            sample_now = sck_lead ^ clock_phase;
            shift_now = ~sample_now && s.edges != '0;
            if (sample_now) begin
                next_s.rx_sh = rx_shifted;
                next_s.edges = s.edges + 4'h1;
            end
            if (shift_now) begin
                next_s.tx_sh = tx_shifted;
            end
            if (next_s.edges == BITS_PER_BYTE) begin
                done = 1'b1;
                done_byte = next_s.rx_sh;
                next_s.edges = '0;
                if (!s.tx_empty_flag) begin
                    next_s.tx_sh = s.tx_buf;
                    next_s.tx_empty_flag = 1'b1;
                end else begin
                    next_s.tx_sh = next_s.rx_sh;
                end
            end
        end

        // mode fault aborts and falls back to slave
        if (fault_hit) begin
            next_s.fault_flag = 1'b1;
            next_s.control_one[C1_MASTER] = 1'b0;
            next_s.eng = ENG_IDLE;
            next_s.edges = '0;
            next_s.sck_gen = clock_polarity;
            done = 1'b0;
        end

        // byte delivery, held back while the bus side sleeps
        if (done && low_power) begin
            next_s.pend_valid = 1'b1;
            next_s.pend_data = done_byte;
            next_s.wake_irq = s.control_one[C1_RX_IRQ]
                & ~master_select;
        end else if (done || (s.pend_valid && !low_power)) begin
            next_s.pend_valid = done ? s.pend_valid : 1'b0;
            if (!next_s.rx_full_flag) begin
                next_s.rx_data = done ? done_byte : s.pend_data;
                next_s.rx_full_flag = 1'b1;
                if (next_s.rx_data == s.match_value) begin
                    next_s.match_flag = 1'b1;
                end
            end
        end

        // flags masked and gated by system_enable
        next_s.irq = system_enable & (
            (s.control_one[C1_RX_IRQ]
                & (s.rx_full_flag | s.fault_flag))
            | (s.control_one[C1_TX_IRQ] & s.tx_empty_flag)
            | (s.control_two[C2_MATCH_IRQ] & s.match_flag));

        // pin drivers; a set fault flag keeps every output released
        drive_master = system_enable & next_s.control_one[C1_MASTER]
            & ~next_s.fault_flag;
        drive_slave = system_enable & ~next_s.control_one[C1_MASTER]
            & ~next_s.fault_flag & ~s.ss_n_s[1];
        next_s.sck_out = next_s.sck_gen;
        next_s.sck_oe_n = ~drive_master;
        next_s.mosi_out = low_bit_first ? next_s.tx_sh[0]
            : next_s.tx_sh[7];
        next_s.miso_out = next_s.mosi_out;
        next_s.mosi_oe_n = ~(drive_master
            & (~single_pin_select | shared_pin_output_enable));
        next_s.miso_oe_n = ~(drive_slave
            & (~single_pin_select | shared_pin_output_enable));
        next_s.ss_oe_n = ~(drive_master & fault_detect_enable
            & select_output_enable);
        next_s.ss_out = next_s.eng != ENG_MASTER;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign irq = s.irq;
    assign wake_irq = s.wake_irq;
    assign sck_out = s.sck_out;
    assign sck_oe_n = s.sck_oe_n;
    assign mosi_out = s.mosi_out;
    assign mosi_oe_n = s.mosi_oe_n;
    assign miso_out = s.miso_out;
    assign miso_oe_n = s.miso_oe_n;
    assign ss_out = s.ss_out;
    assign ss_oe_n = s.ss_oe_n;

endmodule

// ===== test/spi_flag_monitor.sv
`timescale 1ns/1ps
module spi_flag_monitor
    import spi_flag_pkg::*;
(
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic wait_mode, // cpu in wait
    input wire logic stop_mode, // cpu in stop
    input wire logic irq, // interrupt request
    input wire logic wake_irq // wake pulse
);
    logic [7:0] c1;

    // shadow of control_one as written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c1 <= C1_RESET;
        end else if (pready && pwrite && !pslverr
                     && paddr == OFF_CONTROL_ONE) begin
            c1 <= pwdata[7:0];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_wait: assert property (psel && penable && !$past(penable)
        |=> pready) else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_unmapped: assert property (pready && (paddr > OFF_TX_RX_DATA
        || paddr[1:0] != 2'b00) |-> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (pready && paddr <= OFF_TX_RX_DATA
        && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready cycle");
    a_rdata_upper: assert property (prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_irq_disabled: assert property (!c1[C1_ENABLE] |=> !irq)
        else $error("request while module disabled");
    a_wake_pulse: assert property (wake_irq |=> !wake_irq)
        else $error("wake pulse too long");
    a_wake_cond: assert property (wake_irq |-> c1[C1_RX_IRQ]
        && (wait_mode || stop_mode || $past(wait_mode) || $past(stop_mode)))
        else $error("wake without its conditions");
endmodule
bind spi_flag_core spi_flag_monitor mon (.*);

// ===== test/spi_slave_model.sv
`timescale 1ns/1ps
module spi_slave_model (
    input wire logic sck, // serial clock from master
    input wire logic mosi, // data from master
    input wire logic sel_n, // select, active low
    input wire logic [7:0] load, // byte to return
    output logic miso, // data to master
    output logic [7:0] got // last whole byte taken
);
    logic [7:0] tx_sh = 8'h00;
    logic [7:0] rx_sh = 8'h00;
    logic bit_out = 1'b0;
    int n = 0;
    initial got = 8'h00;
    // launch on leading edge, msb first
    always @(posedge sck) begin
        if (!sel_n) begin
            bit_out = (n == 0) ? load[7] : tx_sh[7];
            tx_sh = (n == 0) ? {load[6:0], 1'b0} : {tx_sh[6:0], 1'b0};
        end
    end
    always @(negedge sck) begin
        if (!sel_n) begin
            rx_sh = {rx_sh[6:0], mosi};
            n = (n + 1) % 8;
            if (n == 0) got = rx_sh;
        end
    end
    // released line shows the inverse of the last bit
    assign miso = sel_n ? ~bit_out : bit_out;
endmodule

// ===== test/spi_interrupt_flag_logic_tb.sv
`timescale 1ns/1ps
module spi_interrupt_flag_logic_tb import spi_flag_pkg::*; ();
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, irq, wake_irq, last_err;
    logic wait_mode = 0, stop_mode = 0, ss_n = 1, slv_miso;
    logic sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
    logic ss_out, ss_oe_n;
    logic [7:0] slv_load = 8'h00, slv_got;
    logic wake_seen = 1'b0;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    wire sck_line = sck_oe_n ? 1'b0 : sck_out;
    wire mosi_line = mosi_oe_n ? 1'b1 : mosi_out;
    wire miso_line = miso_oe_n ? slv_miso : miso_out;
    wire ss_line = ss_oe_n ? ss_n : ss_out;

    spi_flag_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .wait_mode, .stop_mode, .irq,
        .wake_irq, .sck_in(sck_line), .sck_out, .sck_oe_n,
        .mosi_in(mosi_line), .mosi_out, .mosi_oe_n, .miso_in(miso_line),
        .miso_out, .miso_oe_n, .ss_in_n(ss_line), .ss_out, .ss_oe_n);
    spi_slave_model slv (.sck(sck_line), .mosi(mosi_line), .sel_n(ss_line),
        .load(slv_load), .miso(slv_miso), .got(slv_got));

    initial forever #12.5 pclk = ~pclk;

    task conclude;
        if (bad_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        if (wake_irq === 1'b1) wake_seen <= 1'b1;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rdv, {24'h0, e});
    endtask

    task settle;
        repeat (5) @(posedge pclk);
    endtask

    task wait_rx;
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, OFF_FLAG_STATUS, 8'h00);
            if (rdv[7] === 1'b1) break;
        end
    endtask

    task t_regs;
        rd(OFF_CONTROL_ONE, C1_RESET);
        rd(OFF_CONTROL_TWO, C2_RESET);
        rd(OFF_BAUD_DIVIDER, BR_RESET);
        rd(OFF_FLAG_STATUS, 8'h20);
        rd(OFF_MATCH_VALUE, MATCH_RESET);
        rd(OFF_TX_RX_DATA, 8'h00);
        apb(1'b1, OFF_CONTROL_TWO, 8'hff);
        rd(OFF_CONTROL_TWO, 8'h9b);
        apb(1'b1, OFF_BAUD_DIVIDER, 8'hff);
        rd(OFF_BAUD_DIVIDER, 8'h7f);
        apb(1'b1, OFF_FLAG_STATUS, 8'hff);
        rd(OFF_FLAG_STATUS, 8'h20);
        apb(1'b1, 8'h18, 8'h55);
        chk(last_err, 1'b1);
        apb(1'b1, OFF_CONTROL_TWO, 8'h00);
    endtask

    task t_transfer;
        apb(1'b1, OFF_CONTROL_TWO, 8'h80);
        apb(1'b1, OFF_BAUD_DIVIDER, 8'h02);
        apb(1'b1, OFF_MATCH_VALUE, 8'h3c);
        apb(1'b1, OFF_CONTROL_ONE, 8'h54);
        slv_load <= 8'h3c;
        ss_n <= 1'b0;
        rd(OFF_FLAG_STATUS, 8'h20);
        apb(1'b1, OFF_TX_RX_DATA, 8'ha5);
        wait_rx;
        chk(rdv, 32'he0);
        settle;
        chk(irq, 1'b1);
        chk(slv_got, 8'ha5);
        rd(OFF_TX_RX_DATA, 8'h3c);
        settle;
        chk(irq, 1'b0);
    endtask

    task t_overrun;
        int i;
        rd(OFF_FLAG_STATUS, 8'h20);
        slv_load <= 8'h5a;
        apb(1'b1, OFF_TX_RX_DATA, 8'h11);
        wait_rx;
        slv_load <= 8'h66;
        apb(1'b1, OFF_TX_RX_DATA, 8'h22);
        for (i = 0; i < 300 && slv_got !== 8'h22; i++) @(posedge pclk);
        settle;
        rd(OFF_FLAG_STATUS, 8'ha0);
        rd(OFF_TX_RX_DATA, 8'h5a);
    endtask

    task t_masks;
        apb(1'b1, OFF_CONTROL_ONE, 8'h74);
        settle;
        chk(irq, 1'b1);
        apb(1'b1, OFF_CONTROL_ONE, 8'h34);
        settle;
        chk(irq, 1'b0);
        rd(OFF_FLAG_STATUS, 8'h20);
    endtask

    task t_fault;
        ss_n <= 1'b1;
        apb(1'b1, OFF_CONTROL_TWO, 8'h10);
        apb(1'b1, OFF_CONTROL_ONE, 8'hd4);
        settle;
        chk(irq, 1'b0);
        ss_n <= 1'b0;
        settle;
        chk(irq, 1'b1);
        rd(OFF_FLAG_STATUS, 8'h30);
        rd(OFF_CONTROL_ONE, 8'hc4);
        chk(irq, 1'b1);
        apb(1'b1, OFF_CONTROL_ONE, 8'hc0);
        settle;
        chk(irq, 1'b0);
        rd(OFF_FLAG_STATUS, 8'h20);
    endtask

    task t_lowpower;
        ss_n <= 1'b1;
        apb(1'b1, OFF_CONTROL_TWO, 8'h02);
        apb(1'b1, OFF_CONTROL_ONE, 8'h54);
        slv_load <= 8'hc3;
        ss_n <= 1'b0;
        rd(OFF_FLAG_STATUS, 8'h20);
        apb(1'b1, OFF_TX_RX_DATA, 8'h96);
        repeat (20) @(posedge pclk);
        wait_mode <= 1'b1;
        repeat (60) @(posedge pclk);
        chk(slv_got, 8'h22);
        wait_mode <= 1'b0;
        wait_rx;
        chk(rdv, 32'ha0);
        chk(slv_got, 8'h96);
        chk(wake_seen, 1'b0);
        rd(OFF_TX_RX_DATA, 8'hc3);
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_transfer;
        t_overrun;
        t_masks;
        t_fault;
        t_lowpower;
        conclude;
    end
endmodule
